// ---- hw/hp_consts.svh ----
// Constants for the host port and configuration pin block
`ifndef HP_CONSTS_SVH
`define HP_CONSTS_SVH
// --------------------------------------------------
// Timing
// --------------------------------------------------
`define HP_SYS_PERIOD_NS 8
`define HP_BUS_PERIOD_NS 160
`define HP_HALF_CYC ((`HP_BUS_PERIOD_NS / `HP_SYS_PERIOD_NS) / 2)
// --------------------------------------------------
// Pin fields and codes
// --------------------------------------------------
`define HP_DW 32
`define HP_PW 4
`define HP_SIZE_BYTE 2'h1
`define HP_SIZE_HALF 2'h2
`define HP_SIZE_WORD 2'h0
`define HP_STAT_LSB 3
`define HP_STAT_W 5
`define HP_CFG_BITS 4'h8
`endif

// ---- hw/hp_pkg.sv ----
// Types used by the host and device ends of the host port
package hp_pkg;
  typedef enum logic [1:0] {HP_W8, HP_W16, HP_W32} hp_width_t;
  typedef enum logic [2:0] {
    HP_SER_SLAVE, HP_SER_MASTER, HP_PAR_MASTER, HP_PAR_SLAVE,
    HP_PERIPH_SYNC, HP_PERIPH_ASYNC
  } hp_cfg_mode_t;
  typedef enum logic [1:0] {HP_D_IDLE, HP_D_USER, HP_D_ARM, HP_D_DRIVE} hp_dev_st_t;
  typedef enum logic [1:0] {HP_H_IDLE, HP_H_ADDR, HP_H_WAIT, HP_H_BACK} hp_host_st_t;
endpackage

// ---- hw/hp_link_if.sv ----
// Pin-level link between host processor and device
`timescale 1ns/100ps
interface hp_link_if;
  logic host_bus_clock;
  logic config_clock;
  logic req_n;
  logic rd_wr;
  logic [1:0] transfer_size;
  logic rd_n;
  logic transfer_ack_n;
  logic transfer_error_ack_n;
  logic retry_request_n;
  logic serial_config_out;
  logic pullup_en;
  logic [31:0] d_host_o;
  logic [31:0] d_host_oe;
  logic [31:0] d_dev_o;
  logic [31:0] d_dev_oe;
  logic [3:0] dp_host_o;
  logic [3:0] dp_host_oe;
  logic [3:0] dp_dev_o;
  logic [3:0] dp_dev_oe;
  logic [31:0] d;
  logic [3:0] byte_parity_bus;
  // Undriven pins float high through pull-ups
  assign d = (d_dev_oe & d_dev_o) | (d_host_oe & d_host_o) | ~(d_dev_oe | d_host_oe);
  assign byte_parity_bus = (dp_dev_oe & dp_dev_o) | (dp_host_oe & dp_host_o)
                         | ~(dp_dev_oe | dp_host_oe);
  modport dev (
    input host_bus_clock, config_clock, req_n, rd_wr, transfer_size, rd_n, d,
    input byte_parity_bus,
    output transfer_ack_n, transfer_error_ack_n, retry_request_n, serial_config_out,
    output pullup_en, d_dev_o, d_dev_oe, dp_dev_o, dp_dev_oe
  );
  modport host (
    output host_bus_clock, config_clock, req_n, rd_wr, transfer_size, rd_n,
    output d_host_o, d_host_oe, dp_host_o, dp_host_oe,
    input transfer_ack_n, transfer_error_ack_n, retry_request_n, d, byte_parity_bus
  );
endinterface

// ---- hw/hp_host_end.sv ----
// Host processor end: bus master and configuration source
`timescale 1ns/100ps
`include "hp_consts.svh"
module hp_host_end
  import hp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  hp_link_if.host lk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [1:0] cmd_size,
  input wire logic [31:0] cmd_wdata,
  output logic resp_valid,
  output logic resp_error,
  output logic [31:0] resp_rdata,
  input wire logic cfg_valid,
  input wire logic cfg_serial,
  input wire logic [7:0] cfg_byte,
  output logic cfg_ready,
  input wire logic status_rd,
  output logic [4:0] status_q
);
  localparam int NS = 39;
  localparam logic [7:0] HALF = 8'(`HP_HALF_CYC);
  // --------------------------------------------------
  // Pin input filter
  // --------------------------------------------------
  logic [NS-1:0] raw, s1, s2, s3, flt, next_flt;
  assign raw = {lk.transfer_ack_n, lk.transfer_error_ack_n, lk.retry_request_n,
                lk.byte_parity_bus, lk.d};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_flt
      assign next_flt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : flt[gi];
    end
  endgenerate
  wire ack_seen = ~flt[38];
  wire tea_seen = ~flt[37];
  wire rtry_seen = ~flt[36];
  // --------------------------------------------------
  // Bus clock divider
  // --------------------------------------------------
  logic [7:0] cnt;
  logic bclk;
  wire tick = (cnt == HALF - 8'h01);
  wire rise = tick & ~bclk;
  wire fall = tick & bclk;
  // --------------------------------------------------
  // Transaction and configuration sequencing
  // --------------------------------------------------
  hp_host_st_t st, next_st;
  // Set once config data leads the next clock rise
  logic rd, req_n, cc, cfg_busy, cfg_ser, cfg_go;
  logic [1:0] sz;
  logic [31:0] wd, d_o, d_oe;
  logic [7:0] csh;
  logic [3:0] cbits;
  wire take_cmd = cmd_valid & cmd_ready;
  wire take_cfg = cfg_valid & cfg_ready;
  wire done_w = ack_seen | tea_seen;
  wire stop_cfg = cfg_busy & cfg_go & rise & (cbits == 4'h1);
  wire [3:0] wpar;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_par
      assign wpar[gi] = ^wd[gi*8 +: 8];
    end
  endgenerate
  always_comb begin
    next_st = st;
    case (st)
      HP_H_IDLE: if (take_cmd) next_st = HP_H_BACK;
      HP_H_BACK: if (fall) next_st = HP_H_ADDR;
      HP_H_ADDR: if (fall) next_st = HP_H_WAIT;
      HP_H_WAIT: begin
        if (rise & done_w) next_st = HP_H_IDLE;
        else if (rise & rtry_seen) next_st = HP_H_BACK;
      end
      default: next_st = HP_H_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 8'h00;
      bclk <= 1'b0;
    end else begin
      cnt <= tick ? 8'h00 : cnt + 8'h01;
      bclk <= tick ? ~bclk : bclk;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      flt <= '1;
      st <= HP_H_IDLE;
      rd <= 1'b0;
      sz <= `HP_SIZE_WORD;
      wd <= 32'h0;
      req_n <= 1'b1;
      cmd_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= 32'h0;
      cc <= 1'b0;
      cfg_busy <= 1'b0;
      cfg_ser <= 1'b0;
      cfg_go <= 1'b0;
      csh <= 8'h0;
      cbits <= 4'h0;
      cfg_ready <= 1'b0;
      d_o <= 32'h0;
      d_oe <= 32'h0;
      status_q <= 5'h0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      flt <= next_flt;
      st <= next_st;
      status_q <= flt[`HP_STAT_LSB +: `HP_STAT_W];
      cmd_ready <= (next_st == HP_H_IDLE) & ~cfg_busy & ~take_cfg;
      cfg_ready <= ~cfg_busy & ~take_cfg & (st == HP_H_IDLE) & ~take_cmd & ~stop_cfg;
      if (take_cmd) begin
        rd <= cmd_read;
        sz <= cmd_size;
        wd <= cmd_wdata;
      end
      if (st == HP_H_BACK && fall) begin
        req_n <= 1'b0;
        d_o <= wd;
        d_oe <= {32{~rd}};
      end
      if (st == HP_H_ADDR && fall) req_n <= 1'b1;
      if (st == HP_H_WAIT && rise && (done_w || rtry_seen)) d_oe <= 32'h0;
      resp_valid <= (st == HP_H_WAIT) & rise & done_w;
      if ((st == HP_H_WAIT) && rise && done_w) begin
        resp_error <= tea_seen;
        resp_rdata <= flt[31:0];
      end
      if (take_cfg) begin
        cfg_busy <= 1'b1;
        cfg_ser <= cfg_serial;
        csh <= cfg_byte;
        cbits <= cfg_serial ? `HP_CFG_BITS : 4'h1;
        cfg_go <= 1'b0;
      end
      // Config data set on the fall, clock rises with the bus clock
      if (cfg_busy && fall) begin
        cc <= 1'b0;
        d_oe <= cfg_ser ? 32'h1 : 32'hFF;
        cfg_go <= 1'b1;
        d_o <= cfg_ser ? {31'h0, csh[7]} : {24'h0, csh};
      end
      if (cfg_busy && cfg_go && rise) begin
        cc <= 1'b1;
        csh <= {csh[6:0], 1'b0};
        cbits <= cbits - 4'h1;
      end
      if (stop_cfg) cfg_busy <= 1'b0;
      if (!cfg_busy && fall) cc <= 1'b0;
      if (!cfg_busy && st == HP_H_IDLE && fall) d_oe <= 32'h0;
    end
  end
  assign lk.host_bus_clock = bclk;
  assign lk.config_clock = cc;
  assign lk.req_n = req_n;
  assign lk.rd_wr = rd;
  assign lk.transfer_size = sz;
  assign lk.rd_n = ~status_rd;
  assign lk.d_host_o = d_o;
  assign lk.d_host_oe = d_oe;
  assign lk.dp_host_o = wpar;
  assign lk.dp_host_oe = {4{d_oe[0] & ~cfg_busy}};
endmodule

// ---- hw/hp_dev_end.sv ----
// Device end: host port slave and configuration pin logic
`timescale 1ns/100ps
`include "hp_consts.svh"
module hp_dev_end
  import hp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  hp_link_if.dev lk,
  input wire logic host_port_en,
  input wire hp_width_t width_sel,
  input wire logic par_en,
  output logic user_req,
  output logic user_req_read,
  output logic [1:0] user_req_size,
  output logic [31:0] user_req_wdata,
  input wire logic user_resp_valid,
  input wire logic user_resp_error,
  input wire logic user_resp_retry,
  input wire logic [31:0] user_rd_data,
  input wire logic cfg_active,
  input wire hp_cfg_mode_t cfg_mode,
  input wire logic [4:0] cfg_status,
  output logic cfg_byte_valid,
  output logic [7:0] cfg_byte,
  input wire logic [31:0] gpio_o,
  input wire logic [31:0] gpio_oe,
  input wire logic [3:0] gpio_dp_o,
  input wire logic [3:0] gpio_dp_oe,
  output logic [35:0] gpio_i
);
  localparam int NS = 43;
  localparam int BCLK = 42;
  localparam int CONFIG_CLOCK = 41;
  localparam int RDN = 40;
  localparam int REQN = 39;
  localparam int RDWR = 38;
  // Clock pins idle low, the rest float high
  localparam logic [NS-1:0] PIN_IDLE = {2'b00, {(NS-2){1'b1}}};
  // --------------------------------------------------
  // Pin input filter, three stages
  // --------------------------------------------------
  logic [NS-1:0] raw, s1, s2, s3, flt, flt_d, next_flt;
  assign raw = {lk.host_bus_clock, lk.config_clock, lk.rd_n, lk.req_n, lk.rd_wr,
                lk.transfer_size, lk.byte_parity_bus, lk.d};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_flt
      assign next_flt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : flt[gi];
    end
  endgenerate
  wire b_rise = flt[BCLK] & ~flt_d[BCLK];
  wire b_fall = ~flt[BCLK] & flt_d[BCLK];
  wire c_rise = flt[CONFIG_CLOCK] & ~flt_d[CONFIG_CLOCK];
  wire [31:0] pin_d = flt[31:0];
  wire [3:0] pin_p = flt[35:32];
  // --------------------------------------------------
  // Lane enables and parity
  // --------------------------------------------------
  wire [3:0] lane_en = (width_sel == HP_W32) ? 4'hF :
                       (width_sel == HP_W16) ? 4'h3 : 4'h1;
  wire [31:0] lane_mask;
  wire [3:0] rd_par, par_bad;
  logic [31:0] rdata;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign lane_mask[gi*8 +: 8] = {8{lane_en[gi]}};
      assign rd_par[gi] = ^rdata[gi*8 +: 8];
      assign par_bad[gi] = lane_en[gi] & (pin_p[gi] != ^pin_d[gi*8 +: 8]);
    end
  endgenerate
  // --------------------------------------------------
  // Transaction state machine
  // --------------------------------------------------
  hp_dev_st_t st, next_st;
  logic rd;
  logic [1:0] term, next_term;
  wire port_on = host_port_en & ~cfg_active;
  wire start = port_on & b_rise & ~flt[REQN];
  wire wr_perr = par_en & ~flt[RDWR] & (|par_bad);
  always_comb begin
    next_st = st;
    next_term = term;
    case (st)
      HP_D_IDLE: begin
        if (start && wr_perr) begin
          next_st = HP_D_ARM;
          next_term = 2'h2;
        end else if (start) begin
          next_st = HP_D_USER;
        end
      end
      HP_D_USER: begin
        if (user_resp_valid) begin
          next_st = HP_D_ARM;
          // Error wins over retry, retry over ack
          next_term = user_resp_error ? 2'h2 : user_resp_retry ? 2'h3 : 2'h1;
        end
      end
      HP_D_ARM: if (b_fall) next_st = HP_D_DRIVE;
      HP_D_DRIVE: if (b_rise) next_st = HP_D_IDLE;
      default: next_st = HP_D_IDLE;
    endcase
    if (!port_on) next_st = HP_D_IDLE;
  end
  wire drv = (next_st == HP_D_DRIVE);
  wire rd_drive = drv & rd & (next_term == 2'h1) & port_on;
  // --------------------------------------------------
  // Configuration capture
  // --------------------------------------------------
  wire ser_mode = (cfg_mode == HP_SER_SLAVE) | (cfg_mode == HP_SER_MASTER);
  wire stat_drv = cfg_active & (cfg_mode == HP_PERIPH_ASYNC) & ~flt[RDN];
  logic [7:0] csh;
  logic [3:0] cbits;
  wire ser_full = (cbits == `HP_CFG_BITS - 4'h1);
  // --------------------------------------------------
  // Pin drive selection
  // --------------------------------------------------
  wire rel = ~cfg_active & ~host_port_en;
  wire [31:0] stat_word = {24'h0, cfg_status, 3'h0};
  wire [31:0] next_d_o = stat_drv ? stat_word : rel ? gpio_o : rdata;
  wire [31:0] next_d_oe = stat_drv ? 32'h0000_00F8 :
                          rel ? gpio_oe : ({32{rd_drive}} & lane_mask);
  wire [3:0] next_dp_o = rel ? gpio_dp_o : rd_par;
  wire [3:0] next_dp_oe = rel ? gpio_dp_oe : ({4{rd_drive & par_en}} & lane_en);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1 <= PIN_IDLE;
      s2 <= PIN_IDLE;
      s3 <= PIN_IDLE;
      flt <= PIN_IDLE;
      flt_d <= PIN_IDLE;
      st <= HP_D_IDLE;
      term <= 2'h0;
      rd <= 1'b0;
      rdata <= 32'h0;
      user_req <= 1'b0;
      user_req_read <= 1'b0;
      user_req_size <= `HP_SIZE_WORD;
      user_req_wdata <= 32'h0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      flt <= next_flt;
      flt_d <= flt;
      st <= next_st;
      term <= next_term;
      user_req <= start & ~wr_perr;
      if (start) begin
        rd <= flt[RDWR];
        user_req_read <= flt[RDWR];
        user_req_size <= flt[37:36];
        user_req_wdata <= pin_d & lane_mask;
      end
      if (st == HP_D_USER && user_resp_valid) rdata <= user_rd_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lk.transfer_ack_n <= 1'b1;
      lk.transfer_error_ack_n <= 1'b1;
      lk.retry_request_n <= 1'b1;
      lk.d_dev_o <= 32'h0;
      lk.d_dev_oe <= 32'h0;
      lk.dp_dev_o <= 4'h0;
      lk.dp_dev_oe <= 4'h0;
      lk.pullup_en <= 1'b0;
      lk.serial_config_out <= 1'b1;
      csh <= 8'h0;
      cbits <= 4'h0;
      cfg_byte <= 8'h0;
      cfg_byte_valid <= 1'b0;
      gpio_i <= 36'h0;
    end else begin
      lk.transfer_ack_n <= ~(drv & (next_term == 2'h1));
      lk.transfer_error_ack_n <= ~(drv & (next_term == 2'h2));
      lk.retry_request_n <= ~(drv & (next_term == 2'h3));
      lk.d_dev_o <= next_d_o;
      lk.d_dev_oe <= next_d_oe;
      lk.dp_dev_o <= next_dp_o;
      lk.dp_dev_oe <= next_dp_oe;
      lk.pullup_en <= cfg_active;
      gpio_i <= flt[35:0];
      cfg_byte_valid <= cfg_active & c_rise & (~ser_mode | ser_full);
      if (!cfg_active) begin
        cbits <= 4'h0;
        lk.serial_config_out <= 1'b1;
      end else if (c_rise) begin
        // Pass the incoming bit down the chain
        lk.serial_config_out <= pin_d[0];
        if (ser_mode) begin
          csh <= {csh[6:0], pin_d[0]};
          cbits <= ser_full ? 4'h0 : cbits + 4'h1;
          if (ser_full) cfg_byte <= {csh[6:0], pin_d[0]};
        end else begin
          cfg_byte <= pin_d[7:0];
        end
      end
    end
  end
endmodule

// ---- bench/hp_link_checker.sv ----
// Concurrent checks on the link between host and device ends
`timescale 1ns/100ps
module hp_link_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic host_bus_clock,
  input wire logic config_clock,
  input wire logic req_n,
  input wire logic rd_wr,
  input wire logic rd_n,
  input wire logic transfer_ack_n,
  input wire logic transfer_error_ack_n,
  input wire logic retry_request_n,
  input wire logic serial_config_out,
  input wire logic pullup_en,
  input wire logic [31:0] d,
  input wire logic [31:0] d_host_oe,
  input wire logic [31:0] d_dev_oe,
  input wire logic [3:0] dp_dev_oe,
  input wire logic [3:0] byte_parity_bus
);
  wire logic term_any;
  assign term_any = ~(transfer_ack_n & transfer_error_ack_n & retry_request_n);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----------------------------
  // Link rules
  // ----------------------------
  one_term_a: assert property (
    $onehot0(~{transfer_ack_n, transfer_error_ack_n, retry_request_n}))
    else $error("two terminators low");
  term_phase_a: assert property ($rose(term_any) |-> !host_bus_clock)
    else $error("terminator began in high clock phase");
  term_len_a: assert property ($rose(term_any) |-> term_any [*4] ##[1:12] !term_any)
    else $error("terminator length wrong");
  req_len_a: assert property ($fell(req_n) |-> !req_n [*8] ##[1:16] req_n)
    else $error("request length wrong");
  wr_drive_a: assert property (!req_n && !rd_wr |-> d_host_oe != 32'h0)
    else $error("write without host data");
  rd_quiet_a: assert property (!req_n && rd_wr |-> d_host_oe == 32'h0)
    else $error("host drives data on read");
  no_clash_a: assert property ((d_dev_oe & d_host_oe) == 32'h0)
    else $error("both ends drive data");
  par_even_a: assert property (
    !transfer_ack_n && dp_dev_oe[0] |-> byte_parity_bus[0] == ^d[7:0])
    else $error("lane parity wrong");
  dout_edge_a: assert property ($changed(serial_config_out) |-> config_clock)
    else $error("daisy output moved off clock rise");
  stat_quiet_a: assert property ((pullup_en && rd_n) [*8] |-> d_dev_oe == 32'h0)
    else $error("device drives data without read strobe");
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench joining host and device ends
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
`define WAITON(s) repeat (4000) if ((s) !== 1'b1) tick()
module testbench;
  import hp_pkg::*;
  logic clk_sys = 0, rst = 1, host_port_en = 1, par_en = 0, cfg_active = 0;
  logic user_resp_valid = 0, user_resp_error = 0, user_resp_retry = 0;
  logic cmd_valid = 0, cmd_read = 0, cfg_valid = 0, cfg_serial = 0, status_rd = 0;
  hp_width_t width_sel = HP_W32;
  hp_cfg_mode_t cfg_mode = HP_SER_SLAVE;
  logic [1:0] cmd_size = 2'h0;
  logic [4:0] cfg_status = 5'h00;
  logic [7:0] h_byte = 8'h00;
  logic [3:0] gpio_dp_o = 4'h0, gpio_dp_oe = 4'h0;
  logic [31:0] user_rd_data = 32'h0, cmd_wdata = 32'h0, gpio_o = 32'h0, gpio_oe = 32'h0;
  logic user_req, user_req_read, cmd_ready, resp_valid, resp_error, cfg_ready, cfg_byte_valid;
  logic [1:0] user_req_size;
  logic [31:0] user_req_wdata, resp_rdata;
  logic [7:0] d_byte;
  logic [4:0] status_q;
  logic [35:0] gpio_i;
  int bad_count = 0, cmp_count = 0, cyc = 0, req_cnt = 0;
  hp_link_if lk ();
  hp_host_end i_hp_host_end (.clk_sys, .rst, .lk(lk.host), .cmd_valid, .cmd_ready, .cmd_read,
    .cmd_size, .cmd_wdata, .resp_valid, .resp_error, .resp_rdata, .cfg_valid, .cfg_serial,
    .cfg_byte(h_byte), .cfg_ready, .status_rd, .status_q);
  hp_dev_end i_hp_dev_end (.clk_sys, .rst, .lk(lk.dev), .host_port_en, .width_sel, .par_en,
    .user_req, .user_req_read, .user_req_size, .user_req_wdata, .user_resp_valid,
    .user_resp_error, .user_resp_retry, .user_rd_data, .cfg_active, .cfg_mode, .cfg_status,
    .cfg_byte_valid, .cfg_byte(d_byte), .gpio_o, .gpio_oe, .gpio_dp_o, .gpio_dp_oe, .gpio_i);
  hp_link_checker i_hp_link_checker (.clk_sys, .rst, .host_bus_clock(lk.host_bus_clock),
    .config_clock(lk.config_clock), .req_n(lk.req_n), .rd_wr(lk.rd_wr), .rd_n(lk.rd_n),
    .transfer_ack_n(lk.transfer_ack_n), .transfer_error_ack_n(lk.transfer_error_ack_n),
    .retry_request_n(lk.retry_request_n), .serial_config_out(lk.serial_config_out),
    .pullup_en(lk.pullup_en), .d(lk.d), .d_host_oe(lk.d_host_oe), .d_dev_oe(lk.d_dev_oe),
    .dp_dev_oe(lk.dp_dev_oe), .byte_parity_bus(lk.byte_parity_bus));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (user_req === 1'b1) req_cnt <= req_cnt + 1;
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end
  // ----------------------------
  // Bus helpers and scenarios
  // ----------------------------
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic do_cmd(input logic rd, input logic [1:0] sz, input logic [31:0] wd,
      input logic err, input logic rty, input logic [31:0] rdat);
    cmd_read = rd;
    cmd_size = sz;
    cmd_wdata = wd;
    cmd_valid = 1;
    `WAITON(cmd_ready);
    tick();
    cmd_valid = 0;
    repeat (rty ? 2 : 1) begin
      `WAITON(user_req);
      `CHK("req_read", rd, user_req_read)
      user_resp_valid = 1;
      user_resp_error = err;
      user_resp_retry = rty;
      user_rd_data = rdat;
      tick();
      user_resp_valid = 0;
      rty = 0;
    end
    `WAITON(resp_valid);
  endtask
  task automatic t_write();
    do_cmd(0, 2'h0, 32'hA5C3_1E0F, 0, 0, 32'h0);
    `CHK("wdata32", 32'hA5C3_1E0F, user_req_wdata)
    width_sel = HP_W16;
    par_en = 1;
    do_cmd(0, 2'h2, 32'hA5C3_1E0F, 0, 0, 32'h0);
    `CHK("wdata16", 32'h0000_1E0F, user_req_wdata)
    `CHK("wr_err", 1'b0, resp_error)
  endtask
  task automatic t_reads();
    hp_width_t w[3] = '{HP_W8, HP_W16, HP_W32};
    logic [1:0] s[3] = '{2'h1, 2'h2, 2'h0};
    logic [31:0] e[3] = '{32'hFFFF_FFCD, 32'hFFFF_ABCD, 32'h1234_ABCD};
    for (int i = 0; i < 3; i++) begin
      width_sel = w[i];
      do_cmd(1, s[i], 32'h0, 0, 0, 32'h1234_ABCD);
      `CHK("rdata", e[i], resp_rdata)
      `CHK("size", s[i], user_req_size)
    end
  endtask
  task automatic t_err_retry();
    int n;
    n = req_cnt;
    do_cmd(0, 2'h0, 32'h0000_00FF, 0, 1, 32'h0);
    `CHK("retry_reqs", n + 2, req_cnt)
    `CHK("retry_err", 1'b0, resp_error)
    do_cmd(1, 2'h0, 32'h0, 1, 0, 32'h0);
    `CHK("bus_err", 1'b1, resp_error)
  endtask
  task automatic t_config();
    hp_cfg_mode_t m[5] = '{HP_SER_SLAVE, HP_SER_MASTER, HP_PAR_MASTER, HP_PAR_SLAVE,
      HP_PERIPH_SYNC};
    logic [7:0] b;
    cfg_active = 1;
    for (int i = 0; i < 5; i++) begin
      cfg_mode = m[i];
      b = 8'hB5 + 8'(i);
      cfg_serial = (i < 2);
      h_byte = b;
      cfg_valid = 1;
      `WAITON(cfg_ready);
      tick();
      cfg_valid = 0;
      `WAITON(cfg_byte_valid);
      if (i < 2) begin
        `CHK("ser_byte", b, d_byte)
        `CHK("dout", b[0], lk.serial_config_out)
      end else begin
        `CHK("par_byte", b, d_byte)
      end
    end
    `CHK("pullup", 1'b1, lk.pullup_en)
  endtask
  task automatic t_status_release();
    cfg_mode = HP_PERIPH_ASYNC;
    cfg_status = 5'h16;
    repeat (12) tick();
    status_rd = 1;
    repeat (20) tick();
    `CHK("status", 5'h16, status_q)
    status_rd = 0;
    repeat (12) tick();
    cfg_active = 0;
    repeat (2) tick();
    host_port_en = 0;
    gpio_o = 32'h0F0F_55AA;
    gpio_oe = 32'hFFFF_FFFF;
    gpio_dp_o = 4'hA;
    gpio_dp_oe = 4'hF;
    repeat (10) tick();
    `CHK("pins", 32'h0F0F_55AA, lk.d)
    `CHK("gpio_in", 36'hA_0F0F_55AA, gpio_i)
    `CHK("pullup_off", 1'b0, lk.pullup_en)
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 0;
    t_write();
    t_reads();
    t_err_retry();
    t_config();
    t_status_release();
    wrap_up();
  end
endmodule
